// File: hdl/csu_pkg.sv
// Constants of the chip-select unit: register indices, field positions,
// fixed read bits, write masks, reset values and the sequencer state encoding.
// Assumes a 32-bit classic Wishbone bus whose byte address is four times the index.
package csu_pkg;

  // Register indices; the byte address is the index times four.
  localparam logic [7:0] CSU_IDX_LOW = 8'hA2;
  localparam logic [7:0] CSU_IDX_PER = 8'hA4;
  localparam logic [7:0] CSU_IDX_MID = 8'hA6;
  localparam logic [7:0] CSU_IDX_AUX = 8'hA8;
  localparam logic [7:0] CSU_IDX_STAT = 8'hAA;

  // Field positions.
  localparam int CSU_RDY_BIT = 2;
  localparam int CSU_WEXT_BIT = 3;
  localparam int CSU_WAIT_LSB = 0;
  localparam int CSU_EX_BIT = 7;
  localparam int CSU_MS_BIT = 6;
  localparam int CSU_SIZE_LSB = 8;
  localparam int CSU_DA_BIT = 7;
  localparam int CSU_PSE_BIT = 6;
  localparam int CSU_UB_LSB = 12;
  localparam int CSU_MBASE_LSB = 9;
  localparam int CSU_PBASE_LSB = 7;

  // Reserved bits read back at their fixed levels; only masked bits are stored.
  localparam logic [15:0] CSU_LOW_FIX = 16'h0F38;
  localparam logic [15:0] CSU_PER_FIX = 16'h0070;
  localparam logic [15:0] CSU_MID_FIX = 16'h01F8;
  localparam logic [15:0] CSU_AUX_FIX = 16'h8038;
  localparam logic [15:0] CSU_LOW_WMASK = 16'h70C7;
  localparam logic [15:0] CSU_PER_WMASK = 16'hFF8F;
  localparam logic [15:0] CSU_MID_WMASK = 16'hFE07;
  localparam logic [15:0] CSU_AUX_WMASK = 16'h7FC7;
  localparam logic [15:0] CSU_REG_RST = 16'h0000;

  // Peripheral window layout: 256-byte slots inside a 2K block.
  localparam int CSU_PSLOT_LSB = 8;
  localparam logic [2:0] CSU_PSLOT_RSVD = 3'h4;
  localparam logic [2:0] CSU_PSLOT_UP0 = 3'h5;
  localparam logic [2:0] CSU_PSLOT_UP1 = 3'h6;

  // Bus-cycle sequencer, Gray along idle, address phase, data phase.
  typedef enum logic [1:0] {
    CSU_IDLE = 2'b00,
    CSU_ADDR = 2'b01,
    CSU_DATA = 2'b11
  } csu_state_t;

endpackage : csu_pkg

// File: hdl/csu_top.sv
// Chip-select unit: decodes each processor bus cycle into active-low selects,
// applies wait states and ready mode, and holds four configuration registers.
// Assumes cycle requests come from same-clock logic; ready and strap are pins.
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module csu_top
  import csu_pkg::*;
#(
  parameter int ADR_W = 10
) (
  // Clock, reset and clock enable.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone register slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Processor bus cycle.
  input wire logic cyc_start_i,
  input wire logic [19:0] cyc_addr_i,
  input wire logic cyc_io_i,
  output logic bus_done_o,
  output logic address_drive_o,
  // Pins from outside.
  input wire logic ext_ready_i,
  input wire logic addr_strap_n_i,
  // Select pins and the psram mode output.
  output logic low_select_n_o,
  output logic [3:0] midrange_selects_n_o,
  output logic [3:0] peripheral_selects_n_o,
  output logic [1:0] upper_peripheral_selects_n_o,
  output logic psram_mode_o
);

  function automatic logic [3:0] csu_lower_waits(input logic [2:0] code);
    logic [3:0] w;
    w = 4'h0;
    unique case (code)
      3'h0: w = 4'h0;
      3'h1: w = 4'h1;
      3'h2: w = 4'h2;
      3'h3: w = 4'h3;
      3'h4: w = 4'h5;
      3'h5: w = 4'h7;
      3'h6: w = 4'h9;
      3'h7: w = 4'hF;
    endcase
    return w;
  endfunction : csu_lower_waits

  // Returns {hit, select index}; a size code that is not one-hot never hits.
  function automatic logic [2:0] csu_mid_decode(input logic [19:0] a, input logic [6:0] base,
                                                input logic [6:0] size);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 7; i++) begin
      if (size == 7'(1 << i)) begin
        r[1:0] = a[11+i +: 2];
      end
    end
    r[2] = $onehot(size) && (((a[19:13] ^ base) & ~(size - 7'h01)) == 7'h00);
    return r;
  endfunction : csu_mid_decode

  function automatic logic [15:0] csu_merge(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] sel, input logic [15:0] wmask);
    logic [15:0] n;
    n = old;
    if (sel[0]) begin
      n[7:0] = d[7:0];
    end
    if (sel[1]) begin
      n[15:8] = d[15:8];
    end
    return n & wmask;
  endfunction : csu_merge

  logic [15:0] low_q;
  logic [15:0] per_q;
  logic [15:0] mid_q;
  logic [15:0] aux_q;
  logic low_wr_q;
  logic per_wr_q;
  logic mid_wr_q;
  logic aux_wr_q;
  logic rdy_s1_q;
  logic rdy_s2_q;
  logic strap_s1_q;
  logic strap_s2_q;
  logic strap_taken_q;
  logic strap_force_q;
  csu_state_t state_q;
  logic [19:0] lat_addr_q;
  logic lat_io_q;
  logic low_hit_q;
  logic mid_hit_q;
  logic [1:0] mid_idx_q;
  logic per_hit_q;
  logic [2:0] per_slot_q;
  logic [3:0] waits_q;
  logic [3:0] cnt_q;
  logic ign_q;

  logic wb_req;
  logic [7:0] wb_idx;
  logic mid_act;
  logic per_act;
  logic [2:0] mid_dec;
  logic low_hit_d;
  logic per_hit_d;
  logic [3:0] waits_d;
  logic ign_d;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_idx = wb_adr_i[9:2];
  assign mid_act = mid_wr_q && aux_wr_q;
  assign per_act = per_wr_q && aux_wr_q;

  // Wishbone slave: answers one cycle after the request, unmapped reads give zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        unique case (wb_idx)
          CSU_IDX_LOW: wb_dat_o <= {16'h0000, low_q | CSU_LOW_FIX};
          CSU_IDX_PER: wb_dat_o <= {16'h0000, per_q | CSU_PER_FIX};
          CSU_IDX_MID: wb_dat_o <= {16'h0000, mid_q | CSU_MID_FIX};
          CSU_IDX_AUX: wb_dat_o <= {16'h0000, aux_q | CSU_AUX_FIX};
          CSU_IDX_STAT: wb_dat_o <= {24'h000000, strap_force_q, state_q, low_wr_q,
                                     per_wr_q, mid_wr_q, aux_wr_q, 1'b0};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Configuration writes; each register also records that it was written.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_q <= CSU_REG_RST;
      per_q <= CSU_REG_RST;
      mid_q <= CSU_REG_RST;
      aux_q <= CSU_REG_RST;
      low_wr_q <= 1'b0;
      per_wr_q <= 1'b0;
      mid_wr_q <= 1'b0;
      aux_wr_q <= 1'b0;
    end else if (ce_i && wb_req && wb_we_i) begin
      unique case (wb_idx)
        CSU_IDX_LOW: begin
          low_q <= csu_merge(low_q, wb_dat_i, wb_sel_i, CSU_LOW_WMASK);
          low_wr_q <= 1'b1;
        end
        CSU_IDX_PER: begin
          per_q <= csu_merge(per_q, wb_dat_i, wb_sel_i, CSU_PER_WMASK);
          per_wr_q <= 1'b1;
        end
        CSU_IDX_MID: begin
          mid_q <= csu_merge(mid_q, wb_dat_i, wb_sel_i, CSU_MID_WMASK);
          mid_wr_q <= 1'b1;
        end
        CSU_IDX_AUX: begin
          aux_q <= csu_merge(aux_q, wb_dat_i, wb_sel_i, CSU_AUX_WMASK);
          aux_wr_q <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // Pin synchronisers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdy_s1_q <= 1'b0;
      rdy_s2_q <= 1'b0;
    end else if (ce_i) begin
      rdy_s1_q <= ext_ready_i;
      rdy_s2_q <= rdy_s1_q;
    end
  end

  // The strap pair keeps sampling through reset, so the pin level is known at release.
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      strap_s1_q <= addr_strap_n_i;
      strap_s2_q <= strap_s1_q;
    end
  end

  // The strap is caught once, on the first enabled edge after reset release.
  // Because of the synchroniser, the pin must be stable a few cycles around release.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_taken_q <= 1'b0;
      strap_force_q <= 1'b0;
    end else if (ce_i && !strap_taken_q) begin
      strap_taken_q <= 1'b1;
      strap_force_q <= !strap_s2_q;
    end
  end

  // Decode of the requested address, prioritised low, then midrange, then peripheral.
  always_comb begin
    mid_dec = csu_mid_decode(cyc_addr_i, mid_q[15:CSU_MBASE_LSB],
                             aux_q[CSU_SIZE_LSB +: 7]);
    low_hit_d = low_wr_q && !cyc_io_i && !cyc_addr_i[19]
                && ((cyc_addr_i[18:16] & ~low_q[CSU_UB_LSB +: 3]) == 3'h0);
    per_hit_d = per_act && (cyc_io_i != aux_q[CSU_MS_BIT])
                && (cyc_addr_i[19:11] == per_q[15:CSU_PBASE_LSB]);
    waits_d = 4'h0;
    ign_d = 1'b1;
    if (low_hit_d) begin
      waits_d = {2'b00, low_q[CSU_WAIT_LSB +: 2]};
      ign_d = low_q[CSU_RDY_BIT];
    end else if (mid_act && !cyc_io_i && mid_dec[2]) begin
      waits_d = {2'b00, mid_q[CSU_WAIT_LSB +: 2]};
      ign_d = mid_q[CSU_RDY_BIT];
    end else if (per_hit_d && cyc_addr_i[10]) begin
      waits_d = {2'b00, aux_q[CSU_WAIT_LSB +: 2]};
      ign_d = aux_q[CSU_RDY_BIT];
    end else if (per_hit_d) begin
      waits_d = csu_lower_waits({per_q[CSU_WEXT_BIT], per_q[CSU_WAIT_LSB +: 2]});
      ign_d = per_q[CSU_RDY_BIT];
    end
  end

  // Bus-cycle sequencer and wait counting.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= CSU_IDLE;
      lat_addr_q <= 20'h00000;
      lat_io_q <= 1'b0;
      low_hit_q <= 1'b0;
      mid_hit_q <= 1'b0;
      mid_idx_q <= 2'h0;
      per_hit_q <= 1'b0;
      per_slot_q <= 3'h0;
      waits_q <= 4'h0;
      cnt_q <= 4'h0;
      ign_q <= 1'b1;
      bus_done_o <= 1'b0;
    end else if (ce_i) begin
      bus_done_o <= 1'b0;
      unique case (state_q)
        CSU_IDLE: begin
          if (cyc_start_i) begin
            state_q <= CSU_ADDR;
            lat_addr_q <= cyc_addr_i;
            lat_io_q <= cyc_io_i;
            low_hit_q <= low_hit_d;
            mid_hit_q <= !low_hit_d && mid_act && !cyc_io_i && mid_dec[2];
            mid_idx_q <= mid_dec[1:0];
            per_hit_q <= !low_hit_d && !(mid_act && !cyc_io_i && mid_dec[2]) && per_hit_d;
            per_slot_q <= cyc_addr_i[CSU_PSLOT_LSB +: 3];
            waits_q <= waits_d;
            cnt_q <= waits_d;
            ign_q <= ign_d;
          end
        end
        CSU_ADDR: begin
          state_q <= CSU_DATA;
        end
        CSU_DATA: begin
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else if (ign_q || rdy_s2_q) begin
            state_q <= CSU_IDLE;
            bus_done_o <= 1'b1;
          end
        end
      endcase
    end
  end

  // Select pins; the low select follows the early address, the rest the ad bus.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_select_n_o <= 1'b1;
      midrange_selects_n_o <= 4'hF;
      peripheral_selects_n_o <= 4'hF;
      upper_peripheral_selects_n_o <= 2'b11;
      address_drive_o <= 1'b0;
      psram_mode_o <= 1'b0;
    end else if (ce_i) begin
      psram_mode_o <= low_wr_q && low_q[CSU_PSE_BIT];
      if (state_q == CSU_IDLE && cyc_start_i) begin
        low_select_n_o <= !low_hit_d;
        address_drive_o <= !(low_hit_d && low_q[CSU_DA_BIT]) || strap_force_q;
      end else if (state_q == CSU_ADDR) begin
        address_drive_o <= 1'b0;
        for (int i = 0; i < 4; i++) begin
          midrange_selects_n_o[i] <= !(mid_hit_q && mid_idx_q == 2'(i));
          peripheral_selects_n_o[i] <= !(per_hit_q && per_slot_q == 3'(i));
        end
        if (per_act && !aux_q[CSU_EX_BIT]) begin
          upper_peripheral_selects_n_o <= {lat_addr_q[2], lat_addr_q[1]};
        end else begin
          upper_peripheral_selects_n_o <= {!(per_hit_q && per_slot_q == CSU_PSLOT_UP1),
                                           !(per_hit_q && per_slot_q == CSU_PSLOT_UP0)};
        end
      end else if (state_q == CSU_DATA && cnt_q == 4'h0 && (ign_q || rdy_s2_q)) begin
        low_select_n_o <= 1'b1;
        midrange_selects_n_o <= 4'hF;
        peripheral_selects_n_o <= 4'hF;
        if (per_act && !aux_q[CSU_EX_BIT]) begin
          upper_peripheral_selects_n_o <= {lat_addr_q[2], lat_addr_q[1]};
        end else begin
          upper_peripheral_selects_n_o <= 2'b11;
        end
      end
    end
  end

  // Helper counting data-phase cycles for the wait-state checks.
  logic [4:0] data_cycles_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_cycles_q <= 5'h00;
    end else if (ce_i) begin
      if (state_q != CSU_DATA) begin
        data_cycles_q <= 5'h00;
      end else if (data_cycles_q != 5'h1F) begin
        data_cycles_q <= data_cycles_q + 5'h01;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_addr_phase;
    ce_i && state_q == CSU_ADDR && mid_hit_q;
  endsequence
  sequence s_mid_low;
    ce_i && midrange_selects_n_o != 4'hF;
  endsequence

  property p_mid_idle;
    !mid_act |-> midrange_selects_n_o == 4'hF;
  endproperty
  a_mid_idle: assert property (p_mid_idle) else $error("midrange select active too early");

  property p_per_idle;
    !per_act |-> (peripheral_selects_n_o == 4'hF && upper_peripheral_selects_n_o == 2'b11);
  endproperty
  a_per_idle: assert property (p_per_idle) else $error("peripheral pin active too early");

  property p_low_idle;
    !low_wr_q |-> low_select_n_o;
  endproperty
  a_low_idle: assert property (p_low_idle) else $error("low select active before write");

  property p_mid_late;
    s_addr_phase |-> midrange_selects_n_o == 4'hF ##1 s_mid_low;
  endproperty
  a_mid_late: assert property (p_mid_late) else $error("midrange select timing wrong");

  property p_space;
    (peripheral_selects_n_o != 4'hF) |-> (lat_io_q != aux_q[CSU_MS_BIT]);
  endproperty
  a_space: assert property (p_space) else $error("peripheral select in wrong space");

  property p_waits;
    (bus_done_o && $past(ign_q)) |-> $past(data_cycles_q) == {1'b0, $past(waits_q)};
  endproperty
  a_waits: assert property (p_waits) else $error("wait-state count wrong");

  property p_ready;
    (bus_done_o && !$past(ign_q)) |-> $past(rdy_s2_q) && $past(data_cycles_q) >= {1'b0, $past(waits_q)};
  endproperty
  a_ready: assert property (p_ready) else $error("cycle ended without ready");

  property p_da;
    (ce_i && state_q == CSU_IDLE && cyc_start_i && low_hit_d && low_q[CSU_DA_BIT]
     && !strap_force_q) |=> !address_drive_o;
  endproperty
  a_da: assert property (p_da) else $error("address driven though disabled");

  property p_strap;
    (ce_i && state_q == CSU_IDLE && cyc_start_i && strap_force_q) |=> address_drive_o;
  endproperty
  a_strap: assert property (p_strap) else $error("strap did not force address drive");

  property p_upper_addr;
    (per_act && !aux_q[CSU_EX_BIT] && state_q == CSU_DATA)
      |-> upper_peripheral_selects_n_o == {lat_addr_q[2], lat_addr_q[1]};
  endproperty
  a_upper_addr: assert property (p_upper_addr) else $error("upper pins not address");

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

endmodule : csu_top

`default_nettype wire

// File: bench/csu_bus_partner.sv
// Model of the memories and peripherals behind the selects: drives the ready pin.
// Assumes the selects are active low and that the bench sets the ready delay between cycles.
`timescale 1ns/1ps
`default_nettype none

module csu_bus_partner (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Selects seen on the bus.
  input wire logic low_select_n_i,
  input wire logic [3:0] midrange_selects_n_i,
  input wire logic [3:0] peripheral_selects_n_i,
  input wire logic [1:0] upper_peripheral_selects_n_i,
  // Cycles from select to ready, and the ready pin.
  input wire logic [3:0] delay_i,
  output logic ext_ready_o
);
  logic sel_any;
  logic [3:0] wait_q;
  logic rdy_q;

  assign sel_any = ~(low_select_n_i & (&midrange_selects_n_i) & (&peripheral_selects_n_i)
                     & (&upper_peripheral_selects_n_i));
  // An unselected device does not hold the pin, so it reads as not ready.
  assign ext_ready_o = sel_any && rdy_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || !sel_any) begin
      wait_q <= 4'h0;
      rdy_q <= 1'b0;
    end else begin
      if (wait_q < delay_i) begin
        wait_q <= wait_q + 4'h1;
      end
      rdy_q <= (wait_q >= delay_i);
    end
  end
endmodule : csu_bus_partner
`default_nettype wire

// File: bench/test_chip_select_unit.sv
// Self-checking bench of the chip-select unit: register tasks and bus-cycle tasks.
// Assumes the design package and top module, and the partner model, are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end

module test_chip_select_unit;
  import csu_pkg::*;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, cyc_start, cyc_io, strap_n, ready;
  logic bus_done, addr_drive, low_n, psram, s_low, ad_seen;
  logic [9:0] wb_adr;
  logic [3:0] wb_sel, mid_n, per_n, s_mid, s_per, dly;
  logic [31:0] wb_wdat, wb_rdat;
  logic [19:0] cyc_addr;
  logic [1:0] up_n, s_up, up_done;
  logic [15:0] rd;
  int fail_count, cmp_count, cycles, lat, lat_f, first_k, i;
  int wtab[8] = '{0, 1, 2, 3, 5, 7, 9, 15};
  logic [2:0] ubtab[4] = '{3'h0, 3'h1, 3'h3, 3'h7};

  csu_top #(.ADR_W(10)) u_csu_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .cyc_start_i(cyc_start), .cyc_addr_i(cyc_addr), .cyc_io_i(cyc_io),
    .bus_done_o(bus_done), .address_drive_o(addr_drive), .ext_ready_i(ready),
    .addr_strap_n_i(strap_n), .low_select_n_o(low_n), .midrange_selects_n_o(mid_n),
    .peripheral_selects_n_o(per_n), .upper_peripheral_selects_n_o(up_n),
    .psram_mode_o(psram));

  csu_bus_partner u_csu_bus_partner (.clk_i(clk_i), .rst_i(rst_i), .low_select_n_i(low_n),
    .midrange_selects_n_i(mid_n), .peripheral_selects_n_i(per_n),
    .upper_peripheral_selects_n_i(up_n), .delay_i(dly), .ext_ready_o(ready));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // A hang anywhere ends the run through the same verdict.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      print_verdict();
    end
  end

  task do_reset(input logic strap);
    @(posedge clk_i);
    rst_i <= 1'b1;
    strap_n <= strap;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_reset

  task wb_xfer(input logic we, input logic [7:0] idx, input logic [15:0] wd);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'b00};
    wb_sel <= 4'h3;
    wb_wdat <= {16'h0000, wd};
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    rd = wb_rdat[15:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb_xfer

  task wr(input logic [7:0] idx, input logic [15:0] wd);
    wb_xfer(1'b1, idx, wd);
  endtask : wr

  task chk_rd(input logic [7:0] idx, input logic [15:0] exp);
    wb_xfer(1'b0, idx, 16'h0000);
    `CHK(rd, exp)
  endtask : chk_rd

  // Runs one bus cycle; records which selects fell, when, and the cycle length.
  task run(input logic [19:0] a, input logic io);
    int k;
    @(posedge clk_i);
    cyc_start <= 1'b1;
    cyc_addr <= a;
    cyc_io <= io;
    @(posedge clk_i);
    cyc_start <= 1'b0;
    {s_low, s_mid, s_per, s_up, ad_seen} = 12'hFFE;
    first_k = 0;
    lat = 0;
    for (k = 1; lat == 0; k++) begin
      @(negedge clk_i);
      if (bus_done === 1'b1) begin
        lat = k;
        up_done = up_n;
      end else begin
        s_low &= low_n;
        s_mid &= mid_n;
        s_per &= per_n;
        s_up &= up_n;
        ad_seen |= addr_drive;
        if (first_k == 0 && (low_n & (&mid_n) & (&per_n) & (&up_n)) === 1'b0) first_k = k;
      end
    end
  endtask : run

  task rx(input logic [19:0] a, input logic io, input logic [10:0] es, input int el);
    run(a, io);
    `CHK({s_low, s_mid, s_per, s_up}, es)
    if (el > 0) `CHK(lat, el)
  endtask : rx

  initial begin
    {rst_i, wb_cyc, wb_stb, wb_we, cyc_start, cyc_io} = 6'h20;
    {wb_adr, wb_sel, wb_wdat, cyc_addr, dly} = '0;
    strap_n = 1'b1;
    {fail_count, cmp_count, cycles} = '0;
    do_reset(1'b1);
    `CHK({low_n, mid_n, per_n, up_n, psram, bus_done}, 13'h1FFC)
    chk_rd(CSU_IDX_LOW, CSU_LOW_FIX);
    chk_rd(CSU_IDX_PER, CSU_PER_FIX);
    chk_rd(CSU_IDX_MID, CSU_MID_FIX);
    chk_rd(CSU_IDX_AUX, CSU_AUX_FIX);
    wr(8'h10, 16'hFFFF);
    chk_rd(8'h10, 16'h0000);
    rx(20'h00000, 1'b0, 11'h7FF, 3);
    $display("reset and register map done");
    for (i = 0; i < 4; i++) begin
      wr(CSU_IDX_LOW, {1'b0, ubtab[i], 12'h004});
      rx({1'b0, ubtab[i], 16'hFFFF}, 1'b0, 11'h3FF, 3);
      rx({1'b0, ubtab[i], 16'hFFFF} + 20'h1, 1'b0, 11'h7FF, 3);
    end
    for (i = 0; i < 4; i++) begin
      wr(CSU_IDX_LOW, 16'h0004 | 16'(i));
      rx(20'h00000, 1'b0, 11'h3FF, 3 + i);
    end
    wr(CSU_IDX_LOW, 16'hFFFF);
    @(negedge clk_i);
    `CHK(psram, 1'b1)
    chk_rd(CSU_IDX_LOW, CSU_LOW_WMASK | CSU_LOW_FIX);
    wr(CSU_IDX_LOW, 16'h0084);
    run(20'h00000, 1'b0);
    `CHK({ad_seen, psram}, 2'b00)
    wr(CSU_IDX_LOW, 16'h0004);
    run(20'h00000, 1'b0);
    `CHK({ad_seen, first_k[3:0]}, 5'h11)
    wr(CSU_IDX_LOW, 16'h0000);
    run(20'h00000, 1'b0);
    lat_f = lat;
    dly <= 4'h8;
    run(20'h00000, 1'b0);
    `CHK(lat >= lat_f + 6, 1'b1)
    wr(CSU_IDX_LOW, 16'h0004);
    rx(20'h00000, 1'b0, 11'h3FF, 3);
    dly <= 4'h0;
    $display("low select done");
    wr(CSU_IDX_MID, 16'h2004);
    rx(20'h20000, 1'b0, 11'h7FF, 3);
    wr(CSU_IDX_AUX, 16'h04C6);
    for (i = 0; i < 4; i++) begin
      rx(20'h21FFF + 20'h2000 * 20'(i), 1'b0, 11'h7FF & ~(11'h040 << i), 3);
      `CHK(first_k, 2)
    end
    rx(20'h28000, 1'b0, 11'h7FF, 3);
    wr(CSU_IDX_MID, 16'h2007);
    rx(20'h20000, 1'b0, 11'h7BF, 6);
    wr(CSU_IDX_MID, 16'h2003);
    dly <= 4'h8;
    run(20'h20000, 1'b0);
    `CHK(lat > 6, 1'b1)
    dly <= 4'h0;
    wr(CSU_IDX_MID, 16'h8004);
    for (i = 0; i < 6; i++) begin
      wr(CSU_IDX_AUX, {1'b0, 7'(1 << i), 8'hC6});
      rx(20'h80000 + (20'h800 << i) * 20'(i % 4), 1'b0, 11'h7FF & ~(11'h040 << (i % 4)), 3);
      rx(20'h80000 + (20'h2000 << i), 1'b0, 11'h7FF, 3);
    end
    $display("midrange selects done");
    rx(20'h30000, 1'b0, 11'h7FF, 3);
    for (i = 0; i < 8; i++) begin
      wr(CSU_IDX_PER, 16'h3004 | {12'h000, i[2], 1'b0, i[1:0]});
      rx(20'h30000 + 20'h100 * 20'(i % 4), 1'b0, 11'h7FF & ~(11'h004 << (i % 4)), 3 + wtab[i]);
    end
    wr(CSU_IDX_PER, 16'h3009);
    run(20'h30000, 1'b0);
    `CHK(lat >= 10, 1'b1)
    rx(20'h30500, 1'b0, 11'h7FE, 5);
    rx(20'h30600, 1'b0, 11'h7FD, 5);
    rx(20'h30400, 1'b0, 11'h7FF, 5);
    rx(20'h30000, 1'b1, 11'h7FF, 3);
    wr(CSU_IDX_AUX, 16'h0486);
    wr(CSU_IDX_PER, 16'h0084);
    rx(20'h00800, 1'b1, 11'h7FB, 3);
    rx(20'h00800, 1'b0, 11'h3FF, 3);
    wr(CSU_IDX_AUX, 16'h0406);
    run(20'h00802, 1'b1);
    `CHK(up_done, 2'b01)
    run(20'h00804, 1'b1);
    `CHK(up_done, 2'b10)
    $display("peripheral selects done");
    do_reset(1'b0);
    rx(20'h20000, 1'b0, 11'h7FF, 3);
    wr(CSU_IDX_MID, 16'h0004);
    wr(CSU_IDX_AUX, 16'h40C6);
    rx(20'h7FFFF, 1'b0, 11'h5FF, 3);
    wr(CSU_IDX_LOW, 16'h0084);
    run(20'h00000, 1'b0);
    `CHK({ad_seen, s_low}, 2'b10)
    $display("strap reset done");
    print_verdict();
  end
endmodule : test_chip_select_unit
`default_nettype wire
